// >>> rtl/pmc_pkg.sv
// Purpose: Shared constants and types for the power mode controller.
// Assumes: One 125 MHz clock; the 32 kHz timing tick arrives as a one-cycle pulse.
// Notes: The power control register fields are kept at their printed positions.
package pmc_pkg;
  // ------------------------------------------------------------
  // Power control register layout
  // ------------------------------------------------------------
  localparam logic [7:0] PWR_CTRL_ADDR = 8'h1B;
  localparam int INVERT_BIT = 6;
  localparam int DELAY_HI = 5;
  localparam int DELAY_LO = 4;
  localparam logic [7:0] PWR_CTRL_RESET = 8'h10;
  localparam logic [1:0] DELAY_NONE = 2'h0;
  localparam logic [1:0] SYNC_ALL_ONE = 2'h3;
  localparam logic [1:0] SYNC_ALL_ZERO = 2'h0;

  // ------------------------------------------------------------
  // Operating states
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_COIN = 5'h02,
    ST_SLEEP = 5'h04,
    ST_STANDBY = 5'h08,
    ST_ON = 5'h10
  } pmc_mode_t;

  typedef struct packed {
    pmc_mode_t mode;
    logic [7:0] pwr_ctrl;
    logic [2:0] pin_sync;
    logic req_stable;
    logic req_seen;
    logic [1:0] delay_cnt;
    logic req_qual;
    logic cfg_copy_done;
    logic cfg_copy;
    logic rst_out;
    logic [7:0] rdata;
  } pmc_state_t;
endpackage

// >>> rtl/pmc_mode_ctrl.sv
// Purpose: Five-state power mode controller with low-power request qualification.
// Assumes: Register access arrives as a decoded write/read strobe pair from an I2C slave.
// Notes: Analog thresholds arrive as comparator levels already in this clock domain.
`timescale 1ns/1ns
module pmc_mode_ctrl
  import pmc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic tick_32k_in,
  input wire logic supply_above_uv_in,
  input wire logic turn_on_in,
  input wire logic turn_off_in,
  input wire logic thermal_shutdown_in,
  input wire logic power_button_in,
  input wire logic switcher_off_mode_sel_in,
  input wire logic lowpower_req_pin_in,
  input wire logic fault_irq_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic processor_reset_out,
  output logic interrupt_out_n,
  output logic digital_core_supply_out,
  output logic backup_domain_supply_out,
  output logic regulators_on_out,
  output logic standby_settings_copy_out,
  output logic [4:0] mode_out
);
  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  pmc_state_t s_q;
  pmc_state_t s_d;
  logic decoded_req;
  logic active;
  logic reg_hit;

  function automatic logic is_active(input pmc_mode_t m);
    is_active = (m == ST_ON) || (m == ST_STANDBY) || (m == ST_SLEEP);
  endfunction

  assign decoded_req = s_q.req_stable ^ s_q.pwr_ctrl[INVERT_BIT];
  assign active = is_active(s_q.mode);
  assign reg_hit = (s_q.mode != ST_COIN) && (reg_addr_in == PWR_CTRL_ADDR);

  always_comb
  begin
    s_d = s_q;
    s_d.cfg_copy = 1'b0;
    if (reg_hit && reg_wr_in)
    begin
      s_d.pwr_ctrl = reg_wdata_in;
    end
    if (reg_hit && reg_rd_in)
    begin
      s_d.rdata = s_q.pwr_ctrl;
    end
    // The pin crosses clock domains, so only the agreed second and third stages are trusted.
    if (tick_32k_in)
    begin
      s_d.pin_sync = {s_q.pin_sync[1:0], lowpower_req_pin_in};
      if (s_q.pin_sync[2:1] == SYNC_ALL_ONE)
      begin
        s_d.req_stable = 1'b1;
      end
      else if (s_q.pin_sync[2:1] == SYNC_ALL_ZERO)
      begin
        s_d.req_stable = 1'b0;
      end
      if (decoded_req != s_q.req_seen)
      begin
        s_d.req_seen = decoded_req;
        s_d.delay_cnt = s_q.pwr_ctrl[DELAY_HI:DELAY_LO];
        if (s_q.pwr_ctrl[DELAY_HI:DELAY_LO] == DELAY_NONE)
        begin
          s_d.req_qual = decoded_req;
        end
      end
      else if (s_q.delay_cnt != DELAY_NONE)
      begin
        s_d.delay_cnt = s_q.delay_cnt - 2'h1;
        if (s_q.delay_cnt == 2'h1)
        begin
          s_d.req_qual = s_q.req_seen;
        end
      end
    end
    case (s_q.mode)
      ST_COIN:
      begin
        if (supply_above_uv_in)
        begin
          s_d.mode = ST_OFF;
        end
      end
      ST_OFF:
      begin
        if (!supply_above_uv_in)
        begin
          s_d.mode = ST_COIN;
        end
        else if (turn_on_in)
        begin
          s_d.mode = ST_ON;
          if (!s_q.cfg_copy_done)
          begin
            s_d.cfg_copy = 1'b1;
            s_d.cfg_copy_done = 1'b1;
          end
        end
      end
      ST_ON:
      begin
        if (thermal_shutdown_in || turn_off_in)
        begin
          s_d.mode = ST_OFF;
        end
        else if (!power_button_in && switcher_off_mode_sel_in)
        begin
          s_d.mode = ST_SLEEP;
        end
        else if (s_q.req_qual)
        begin
          s_d.mode = ST_STANDBY;
        end
      end
      ST_STANDBY:
      begin
        if (thermal_shutdown_in || turn_off_in)
        begin
          s_d.mode = ST_OFF;
        end
        else if (!s_q.req_qual)
        begin
          s_d.mode = ST_ON;
        end
      end
      ST_SLEEP:
      begin
        if (thermal_shutdown_in || turn_off_in)
        begin
          s_d.mode = ST_OFF;
        end
        else if (power_button_in)
        begin
          s_d.mode = ST_ON;
        end
      end
      default:
      begin
        s_d.mode = ST_OFF;
      end
    endcase
    s_d.rst_out = is_active(s_d.mode);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_q <= '{mode: ST_COIN, pwr_ctrl: PWR_CTRL_RESET, default: '0};
    end
    else if (clk_en_in)
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out = s_q.rdata;
  assign processor_reset_out = s_q.rst_out;
  assign interrupt_out_n = ~(active && fault_irq_in);
  assign digital_core_supply_out = s_q.mode != ST_COIN;
  assign backup_domain_supply_out = 1'b1;
  assign regulators_on_out = active;
  assign standby_settings_copy_out = s_q.cfg_copy;
  assign mode_out = s_q.mode;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence seq_fault_in_off;
    !active && fault_irq_in;
  endsequence

  a_one_hot_mode: assert property (@(posedge ref_clk_in) disable iff (rst_in) $onehot(s_q.mode))
    else $error("mode is not one-hot");
  a_coin_needs_supply: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (s_q.mode == ST_COIN) && !supply_above_uv_in |=> s_q.mode == ST_COIN)
    else $error("left coin cell without supply");
  a_coin_no_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (s_q.mode == ST_COIN) |=> $stable(s_q.pwr_ctrl))
    else $error("register changed in coin cell");
  a_irq_gated: assert property (@(posedge ref_clk_in) disable iff (rst_in) seq_fault_in_off |-> interrupt_out_n)
    else $error("interrupt active while off");
  a_on_reset_high: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (s_q.mode == ST_ON) |-> processor_reset_out)
    else $error("reset low while on");
  a_off_reset_low: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (s_q.mode == ST_OFF) || (s_q.mode == ST_COIN) |-> !processor_reset_out)
    else $error("reset high while off");
  a_thermal_off: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    clk_en_in && active && thermal_shutdown_in |=> s_q.mode == ST_OFF)
    else $error("thermal shutdown ignored");
  a_pin_only_on: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    clk_en_in && (s_q.mode == ST_SLEEP) && !power_button_in && !turn_off_in && !thermal_shutdown_in
    |=> s_q.mode == ST_SLEEP)
    else $error("sleep left without cause");
  // A restart that returns to the qualified level is harmless, so only the qualified level itself is watched.
  a_delay_holdoff: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    clk_en_in && (s_q.delay_cnt > 2'h1) && (s_q.pwr_ctrl[DELAY_HI:DELAY_LO] != DELAY_NONE)
    |=> $stable(s_q.req_qual))
    else $error("standby response not held off");
endmodule

// >>> bench/pmc_host_model.sv
// Purpose: Host model that drives the low-power request pin and register strobes.
// Assumes: Everything changes on the falling clock edge; strobes last one cycle.
// Notes: A released address shows its inverse so stale values never look valid.
`timescale 1ns/1ns
module pmc_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic pin_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  initial
  begin
    pin_out = 1'b0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end

  // ------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_in);
    wr_out <= wr;
    rd_out <= !wr;
    addr_out <= a;
    wdata_out <= d;
    @(negedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
    @(negedge clk_in);
    q = rdata_in;
  endtask
endmodule

// >>> bench/test_pmic_mode_standby_control.sv
// Purpose: Self-checking bench for the power mode controller.
// Assumes: A 32 kHz tick every 16 clocks stands in for the slow timebase.
// Notes: The request latency is checked as a window, since the pin is asynchronous.
`timescale 1ns/1ns
module test_pmic_mode_standby_control;
  import pmc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, tick = 1'b0, sup, ton, toff, therm, btn, sel, fault;
  logic pin, wr, rd, rst_o, irq_n, core, bkp, copy;
  logic [7:0] addr, wdata, rdata, q, r;
  logic [4:0] mode;
  logic [3:0] tcnt = 4'h0;
  int failures = 0, tests_run = 0, copies = 0, lat, d, i;

  always #4 clk = ~clk;
  always @(negedge clk)
  begin
    tcnt <= tcnt + 4'h1;
    tick <= (tcnt == 4'hF);
  end
  always @(posedge clk) copies <= copies + int'(copy === 1'b1);

  pmc_host_model host (.clk_in(clk), .rdata_in(rdata), .pin_out(pin), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .wdata_out(wdata));
  pmc_mode_ctrl dut (.ref_clk_in(clk), .rst_in(rst), .clk_en_in(1'b1), .tick_32k_in(tick),
    .supply_above_uv_in(sup), .turn_on_in(ton), .turn_off_in(toff), .thermal_shutdown_in(therm),
    .power_button_in(btn), .switcher_off_mode_sel_in(sel), .lowpower_req_pin_in(pin),
    .fault_irq_in(fault), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .processor_reset_out(rst_o), .interrupt_out_n(irq_n),
    .digital_core_supply_out(core), .backup_domain_supply_out(bkp), .regulators_on_out(),
    .standby_settings_copy_out(copy), .mode_out(mode));

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // The model's expected mode is handed in; a bound that runs out ends the run.
  task automatic wait_mode(input logic [4:0] m, output int ticks);
    int n;
    ticks = 0;
    for (n = 0; n < 400 && mode !== m; n++)
    begin
      @(negedge clk);
      ticks += int'(tick);
    end
    check("mode", {3'h0, mode}, {3'h0, m});
    if (mode !== m)
      tally_and_finish();
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {sup, ton, toff, therm, sel, fault} = 6'h00;
    btn = 1'b1;
    void'($urandom(32'h1233));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    ton = 1'b1;
    repeat (4) @(negedge clk);
    check("mode", {3'h0, mode}, {3'h0, ST_COIN});
    check("reset", {7'h0, rst_o}, 8'h00);
    host.access(1'b1, PWR_CTRL_ADDR, 8'h7F, q);
    host.access(1'b0, PWR_CTRL_ADDR, 8'h00, q);
    check("coin read", q, 8'h00);
    ton = 1'b0;
    sup = 1'b1;
    fault = 1'b1;
    wait_mode(ST_OFF, lat);
    check("supplies", {6'h0, core, bkp}, 8'h03);
    check("irq off", {7'h0, irq_n}, 8'h01);
    ton = 1'b1;
    wait_mode(ST_ON, lat);
    ton = 1'b0;
    check("reset on", {7'h0, rst_o}, 8'h01);
    check("irq on", {7'h0, irq_n}, 8'h00);
    host.access(1'b0, PWR_CTRL_ADDR, 8'h00, q);
    check("default", q, PWR_CTRL_RESET);
    // Each delay setting is run through a full request so the counter sees every load value.
    for (d = 0; d < 4; d++)
    begin
      r = 8'($urandom);
      host.access(1'b1, PWR_CTRL_ADDR, {r[7], 1'b0, 2'(d), r[3:0]}, q);
      host.access(1'b0, PWR_CTRL_ADDR, 8'h00, q);
      check("ctrl field", {1'b0, q[6:4], 4'h0}, {2'h0, 1'(d / 2), 1'(d % 2), 4'h0});
      pin = 1'b1;
      wait_mode(ST_STANDBY, lat);
      check("lat lo", {7'h0, 1'(lat >= d + 3)}, 8'h01);
      check("lat hi", {7'h0, 1'(lat <= d + 5)}, 8'h01);
      pin = 1'b0;
      wait_mode(ST_ON, lat);
    end
    toff = 1'b1;
    wait_mode(ST_OFF, lat);
    toff = 1'b0;
    host.access(1'b1, PWR_CTRL_ADDR, 8'h40, q);
    for (i = 0; i < 20; i++)
    begin
      pin = 1'($urandom);
      repeat (10) @(negedge clk);
      check("pin ignored", {3'h0, mode}, {3'h0, ST_OFF});
    end
    pin = 1'b1;
    // The random pin may leave a stale request qualified, so let eight ticks settle it first.
    repeat (128) @(negedge clk);
    check("pin settled", {3'h0, mode}, {3'h0, ST_OFF});
    ton = 1'b1;
    wait_mode(ST_ON, lat);
    ton = 1'b0;
    pin = 1'b0;
    wait_mode(ST_STANDBY, lat);
    pin = 1'b1;
    wait_mode(ST_ON, lat);
    sel = 1'b1;
    btn = 1'b0;
    wait_mode(ST_SLEEP, lat);
    check("irq sleep", {7'h0, irq_n}, 8'h00);
    btn = 1'b1;
    wait_mode(ST_ON, lat);
    therm = 1'b1;
    wait_mode(ST_OFF, lat);
    check("reset off", {7'h0, rst_o}, 8'h00);
    check("copies", 8'(copies), 8'h01);
    tally_and_finish();
  end
endmodule
